/* File: rtl/isab_defs.svh */
// Constants shared by both ends of the expansion bus link
`ifndef ISAB_DEFS_SVH
`define ISAB_DEFS_SVH
`define ISAB_KBC_PORT_DATA 16'h0060
`define ISAB_KBC_PORT_CMD 16'h0064
`define ISAB_KBC_DISABLE_BIT 7
`define ISAB_ROM_BASE 24'h0f0000
`define ISAB_ROM_MASK 24'hff0000
`define ISAB_LOW_MEG_MASK 24'hf00000
`define ISAB_ROM_WAITS 3'h1
`define ISAB_STD_WAITS 3'h4
`define ISAB_CMD_T2_FIRST 3'h0
`endif

/* File: rtl/isab_pkg.sv */
// Types for the expansion bus controller
package isab_pkg;
   typedef enum logic [5:0] {
      ISAB_IDLE = 6'h01,
      ISAB_HOLD = 6'h02,
      ISAB_ALE = 6'h04,
      ISAB_CMD = 6'h08,
      ISAB_WAIT = 6'h10,
      ISAB_END = 6'h20
   } isab_state_t;
   typedef enum logic [1:0] {
      ISAB_OWN_CPU = 2'h0,
      ISAB_OWN_DMA = 2'h1,
      ISAB_OWN_REF = 2'h2,
      ISAB_OWN_MST = 2'h3
   } isab_owner_t;
endpackage : isab_pkg

/* File: rtl/isab_if.sv */
// Pin bundle between the controller end and the card or master end
`timescale 1ns/100ps
interface isab_if;
   logic [1:0] sa_c_o, sa_c_oe, sa_p_o, sa_p_oe;
   logic [15:0] sd_c_o, sd_p_o;
   logic sd_c_oe, sd_p_oe;
   logic sbhe_n_c_o, sbhe_n_c_oe, sbhe_n_p_o, sbhe_n_p_oe;
   logic [3:0] cmd_n_c_o, cmd_n_c_oe, cmd_n_p_o, cmd_n_p_oe;
   logic mem_sixteen_bit_select_n_n_c_o, mem_sixteen_bit_select_n_n_c_oe, mem_sixteen_bit_select_n_n_p_o, mem_sixteen_bit_select_n_n_p_oe;
   logic refresh_active_n_n_c_o, refresh_active_n_n_c_oe, refresh_active_n_n_p_o, refresh_active_n_n_p_oe;
   logic [23:0] la;
   logic ale, low_meg_select_n, bios_rom_or_kbc_select_n;
   logic iocs16_n, chrdy, zero_wait_or_local_ready_in_n;
   logic hold, cpu_bus_grant, master_req;
   // Resolved levels, pulled high where nobody drives
   logic [1:0] sa;
   logic [15:0] sd;
   logic sbhe_n, mem_sixteen_bit_select_n_n, refresh_active_n_n;
   logic [3:0] cmd_n;
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         sa[i] = sa_c_oe[i] ? sa_c_o[i] : (sa_p_oe[i] ? sa_p_o[i] : 1'b1);
      end
      for (int i = 0; i < 4; i++) begin
         cmd_n[i] = cmd_n_c_oe[i] ? cmd_n_c_o[i] : (cmd_n_p_oe[i] ? cmd_n_p_o[i] : 1'b1);
      end
      sd = sd_c_oe ? sd_c_o : (sd_p_oe ? sd_p_o : 16'hffff);
      sbhe_n = sbhe_n_c_oe ? sbhe_n_c_o : (sbhe_n_p_oe ? sbhe_n_p_o : 1'b1);
      mem_sixteen_bit_select_n_n = (mem_sixteen_bit_select_n_n_c_oe & ~mem_sixteen_bit_select_n_n_c_o) | (mem_sixteen_bit_select_n_n_p_oe & ~mem_sixteen_bit_select_n_n_p_o) ? 1'b0 : 1'b1;
      refresh_active_n_n = refresh_active_n_n_c_oe ? refresh_active_n_n_c_o : (refresh_active_n_n_p_oe ? refresh_active_n_n_p_o : 1'b1);
   end
   modport ctrl (
      output sa_c_o, sa_c_oe, sd_c_o, sd_c_oe, sbhe_n_c_o, sbhe_n_c_oe, cmd_n_c_o, cmd_n_c_oe,
      output mem_sixteen_bit_select_n_n_c_o, mem_sixteen_bit_select_n_n_c_oe, refresh_active_n_n_c_o, refresh_active_n_n_c_oe, la, ale, low_meg_select_n,
      output bios_rom_or_kbc_select_n, hold,
      input sa, sd, sbhe_n, cmd_n, mem_sixteen_bit_select_n_n, refresh_active_n_n, iocs16_n, chrdy,
      input zero_wait_or_local_ready_in_n, cpu_bus_grant, master_req
   );
   modport peer (
      output sa_p_o, sa_p_oe, sd_p_o, sd_p_oe, sbhe_n_p_o, sbhe_n_p_oe, cmd_n_p_o, cmd_n_p_oe,
      output mem_sixteen_bit_select_n_n_p_o, mem_sixteen_bit_select_n_n_p_oe, refresh_active_n_n_p_o, refresh_active_n_n_p_oe, iocs16_n, chrdy,
      output zero_wait_or_local_ready_in_n, cpu_bus_grant, master_req,
      input sa, sd, sbhe_n, cmd_n, mem_sixteen_bit_select_n_n, refresh_active_n_n, la, ale, low_meg_select_n,
      input bios_rom_or_kbc_select_n, hold
   );
endinterface : isab_if

/* File: rtl/isab_ctrl.sv */
// Controller end: runs AT bus cycles for CPU, DMA and refresh, yields to masters
`timescale 1ns/100ps
`include "isab_defs.svh"
module isab_ctrl (
   input wire logic mclk,
   input wire logic reset,
   isab_if.ctrl bus,
   input wire logic ready_function_strap,
   input wire logic [7:0] cfg_3a,
   input wire logic req_valid,
   input wire isab_pkg::isab_owner_t req_owner,
   input wire logic req_io,
   input wire logic req_write,
   input wire logic [23:0] req_addr,
   input wire logic req_bhe_n,
   input wire logic [15:0] req_wdata,
   output logic req_ready,
   output logic done,
   output logic [15:0] rdata,
   output logic wide,
   output logic master_active,
   output logic local_ready_in_n
);
   // Whole controller state; one comb copy, one register
   typedef struct packed {
      isab_pkg::isab_state_t state;
      isab_pkg::isab_owner_t owner;
      logic io;
      logic write;
      logic [23:0] addr;
      logic bhe_n;
      logic [15:0] wdata;
      logic [2:0] waits;
      logic rom;
      logic kbc;
      logic rom_en;
      logic zws_mode;
      logic done;
      logic [15:0] rdata;
      logic wide;
   } isab_st_t;
   isab_st_t st_reg, st_next;
   logic cmd_phase, drive_bus, need_hold, is_rom, is_kbc;

   // Decodes on the request being taken
   // ROM decode is memory only, so I/O to the same low bits never opens it
   assign is_rom = ((req_addr & `ISAB_ROM_MASK) == `ISAB_ROM_BASE) & ~req_io;
   assign is_kbc = req_io & ((req_addr[15:0] == `ISAB_KBC_PORT_DATA) |
                             (req_addr[15:0] == `ISAB_KBC_PORT_CMD));
   // hold for DMA or master ownership
   assign need_hold = req_valid & (req_owner == isab_pkg::ISAB_OWN_DMA |
                                   req_owner == isab_pkg::ISAB_OWN_MST);
   assign req_ready = (st_reg.state == isab_pkg::ISAB_IDLE) & ~need_hold |
                      (st_reg.state == isab_pkg::ISAB_HOLD) & bus.cpu_bus_grant;

   always_comb begin
      st_next = st_reg;
      st_next.done = 1'b0;
      case (st_reg.state)
         isab_pkg::ISAB_IDLE: begin
            if (req_valid) begin
               st_next.owner = req_owner;
               st_next.io = req_io;
               st_next.write = req_write;
               st_next.addr = req_addr;
               st_next.bhe_n = req_bhe_n;
               st_next.wdata = req_wdata;
               st_next.rom = is_rom;
               st_next.kbc = is_kbc & ~cfg_3a[`ISAB_KBC_DISABLE_BIT];
               // ROM gets exactly one wait state
               st_next.waits = is_rom ? `ISAB_ROM_WAITS : `ISAB_STD_WAITS;
               st_next.state = need_hold ? isab_pkg::ISAB_HOLD : isab_pkg::ISAB_ALE;
            end
         end
         isab_pkg::ISAB_HOLD: begin
            if (bus.cpu_bus_grant) begin
               // Masters skip ALE and CMD; they run their own strobes
               st_next.state = (st_reg.owner == isab_pkg::ISAB_OWN_MST) ?
                               isab_pkg::ISAB_WAIT : isab_pkg::ISAB_ALE;
            end
         end
         isab_pkg::ISAB_ALE: st_next.state = isab_pkg::ISAB_CMD;
         isab_pkg::ISAB_CMD: begin
            // enable starts at end of first T2
            st_next.rom_en = st_reg.rom | st_reg.kbc;
            st_next.wide = st_reg.io ? ~bus.iocs16_n : ~bus.mem_sixteen_bit_select_n_n;
            st_next.state = isab_pkg::ISAB_WAIT;
         end
         isab_pkg::ISAB_WAIT: begin
            if (st_reg.owner == isab_pkg::ISAB_OWN_MST) begin
               // Master owns bus until it drops its request
               if (!bus.master_req) begin
                  st_next.state = isab_pkg::ISAB_END;
               end
            // channel ready low stretches the cycle
            end else if (bus.chrdy) begin
               // Zero-wait input ends early except fixed ROM timing
               if (st_reg.waits == 3'h0 |
                   (st_reg.zws_mode & ~bus.zero_wait_or_local_ready_in_n & ~st_reg.rom)) begin
                  st_next.rdata = bus.sd;
                  st_next.state = isab_pkg::ISAB_END;
               end else begin
                  st_next.waits = st_reg.waits - 3'h1;
               end
            end
         end
         isab_pkg::ISAB_END: begin
            st_next.rom_en = 1'b0;
            st_next.done = 1'b1;
            st_next.state = isab_pkg::ISAB_IDLE;
         end
         default: st_next.state = isab_pkg::ISAB_IDLE;
      endcase
   end

   // Strap captured while reset holds, constant reset elsewhere
   always_ff @(posedge mclk) begin
      if (reset) begin
         st_reg <= '0;
         st_reg.state <= isab_pkg::ISAB_IDLE;
         // strap picks zero-wait or local ready
         st_reg.zws_mode <= ready_function_strap;
      end else begin
         st_reg <= st_next;
      end
   end

   // Command strobes span CMD and every WAIT state
   assign cmd_phase = (st_reg.state == isab_pkg::ISAB_CMD) |
                      (st_reg.state == isab_pkg::ISAB_WAIT);
   // A master owns the pins once granted, through its END state
   assign master_active = (st_reg.owner == isab_pkg::ISAB_OWN_MST) &
                          (st_reg.state != isab_pkg::ISAB_IDLE) &
                          (st_reg.state != isab_pkg::ISAB_HOLD);
   // no address, data or command pin driven while grant awaited
   assign drive_bus = ~master_active & (st_reg.state != isab_pkg::ISAB_IDLE) &
                      (st_reg.state != isab_pkg::ISAB_HOLD);

   // Pin drive; address, data and command enables drop when idle or under a master
   always_comb begin
      bus.sa_c_o = st_reg.addr[1:0];
      bus.sa_c_oe = {2{drive_bus}};
      bus.la = st_reg.addr;
      // data only driven on our writes
      bus.sd_c_o = st_reg.wdata;
      bus.sd_c_oe = drive_bus & st_reg.write & cmd_phase;
      // high byte enable released to master
      bus.sbhe_n_c_o = st_reg.bhe_n;
      bus.sbhe_n_c_oe = drive_bus;
      bus.cmd_n_c_o = 4'hf;
      if (cmd_phase & (st_reg.owner != isab_pkg::ISAB_OWN_REF)) begin
         // Bit 3 down: iord, iowr, memr, memw; the card decodes the same order
         bus.cmd_n_c_o = ~{st_reg.io & ~st_reg.write, st_reg.io & st_reg.write,
                           ~st_reg.io & ~st_reg.write, ~st_reg.io & st_reg.write};
      end else if (cmd_phase) begin
         bus.cmd_n_c_o = 4'hd;
      end
      bus.cmd_n_c_oe = {4{drive_bus}};
      // drive 16-bit memory select low for masters
      bus.mem_sixteen_bit_select_n_n_c_o = 1'b0;
      bus.mem_sixteen_bit_select_n_n_c_oe = master_active;
      // refresh driven unless master or DMA
      bus.refresh_active_n_n_c_o = ~(st_reg.owner == isab_pkg::ISAB_OWN_REF & drive_bus);
      bus.refresh_active_n_n_c_oe = ~(master_active | st_reg.owner == isab_pkg::ISAB_OWN_DMA &
                          st_reg.state != isab_pkg::ISAB_IDLE);
      // address latch enable at cycle start
      bus.ale = st_reg.state == isab_pkg::ISAB_ALE;
      bus.low_meg_select_n = ~(~st_reg.io & ((st_reg.addr & `ISAB_LOW_MEG_MASK) == 24'h0) &
                               drive_bus);
      bus.bios_rom_or_kbc_select_n = ~st_reg.rom_en;
      // Hold stays up through a DMA cycle so the CPU cannot slip in
      bus.hold = (st_reg.state == isab_pkg::ISAB_HOLD) | master_active |
                 (st_reg.owner == isab_pkg::ISAB_OWN_DMA & drive_bus);
   end

   // Status outputs straight from the state register
   assign done = st_reg.done;
   assign rdata = st_reg.rdata;
   assign wide = st_reg.wide;
   // Local ready passes only when the strap chose it; fixed high otherwise
   assign local_ready_in_n = st_reg.zws_mode | bus.zero_wait_or_local_ready_in_n;
endmodule : isab_ctrl

/* File: rtl/isab_peer.sv */
// Far end: an ISA slave card model with bus-master ability and the CPU grant
`timescale 1ns/100ps
`include "isab_defs.svh"
module isab_peer (
   input wire logic mclk,
   input wire logic reset,
   isab_if.peer bus,
   input wire logic slave_wide_mem,
   input wire logic slave_wide_io,
   input wire logic slave_not_ready,
   input wire logic slave_zero_wait_n,
   input wire logic [15:0] slave_rdata,
   input wire logic mst_req,
   input wire logic [1:0] mst_sa,
   input wire logic mst_bhe_n,
   input wire logic [3:0] mst_cmd_n,
   input wire logic [15:0] mst_wdata,
   input wire logic mst_write,
   output logic mst_granted,
   output logic [15:0] slave_wdata,
   output logic slave_wstrobe
);
   typedef struct packed {
      logic grant;
      logic [15:0] wdata;
      logic wstrobe;
      logic [3:0] cmd_prev;
   } isab_pst_t;
   isab_pst_t st_reg, st_next;
   logic reading;

   // CPU grants one cycle after hold, drops one cycle after it
   always_comb begin
      st_next = st_reg;
      st_next.grant = bus.hold;
      st_next.cmd_prev = bus.cmd_n;
      // Capture write data while a write strobe is low; pulse wstrobe on its rise
      st_next.wstrobe = (~st_reg.cmd_prev[0] & bus.cmd_n[0]) | (~st_reg.cmd_prev[2] & bus.cmd_n[2]);
      if (~bus.cmd_n[0] | ~bus.cmd_n[2]) begin
         st_next.wdata = bus.sd;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         st_reg <= '0;
         st_reg.cmd_prev <= 4'hf;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reading = ~bus.cmd_n[1] | ~bus.cmd_n[3];
   assign mst_granted = st_reg.grant & bus.hold;
   assign slave_wdata = st_reg.wdata;
   assign slave_wstrobe = st_reg.wstrobe;

   // Slave answers and master drive
   always_comb begin
      bus.cpu_bus_grant = st_reg.grant;
      bus.master_req = mst_req;
      bus.iocs16_n = ~slave_wide_io;
      bus.chrdy = ~slave_not_ready;
      bus.zero_wait_or_local_ready_in_n = slave_zero_wait_n;
      bus.mem_sixteen_bit_select_n_n_p_o = 1'b0;
      bus.mem_sixteen_bit_select_n_n_p_oe = slave_wide_mem & ~mst_granted;
      bus.sa_p_o = mst_sa;
      bus.sa_p_oe = {2{mst_granted}};
      bus.sbhe_n_p_o = mst_bhe_n;
      bus.sbhe_n_p_oe = mst_granted;
      bus.cmd_n_p_o = mst_cmd_n;
      bus.cmd_n_p_oe = {4{mst_granted}};
      bus.refresh_active_n_n_p_o = 1'b1;
      bus.refresh_active_n_n_p_oe = 1'b0;
      // slave read data or master write data
      bus.sd_p_o = mst_granted ? mst_wdata : slave_rdata;
      bus.sd_p_oe = mst_granted ? mst_write : reading;
   end
endmodule : isab_peer

/* File: bench/isab_asserts.sv */
// Concurrent checks on the expansion bus link between both ends
`timescale 1ns/100ps
`include "isab_defs.svh"
module isab_asserts (
   input wire logic mclk,
   input wire logic reset,
   input wire logic ale,
   input wire logic hold,
   input wire logic cpu_bus_grant,
   input wire logic chrdy,
   input wire logic low_meg_select_n,
   input wire logic bios_rom_or_kbc_select_n,
   input wire logic [23:0] la,
   input wire logic [3:0] cmd_n,
   input wire logic [1:0] sa_c_oe,
   input wire logic [3:0] cmd_n_c_oe,
   input wire logic sd_c_oe,
   input wire logic sbhe_n_c_oe,
   input wire logic refresh_active_n_n_c_oe,
   input wire logic mem_sixteen_bit_select_n_n_c_o,
   input wire logic mem_sixteen_bit_select_n_n_c_oe
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   // Controller pulling the 16-bit memory select low marks a master phase
   logic mst_drv;
   assign mst_drv = mem_sixteen_bit_select_n_n_c_oe & ~mem_sixteen_bit_select_n_n_c_o;
   ale_pulse_a: assert property (ale |=> !ale)
      else $error("address latch enable longer than one cycle");
   ale_addr_a: assert property (ale |-> sa_c_oe == 2'h3)
      else $error("low address lines not driven at cycle start");
   cmd_follow_a: assert property (ale |=> cmd_n != 4'hf)
      else $error("no command strobe after cycle start");
   master_float_a: assert property (mst_drv |-> !refresh_active_n_n_c_oe && !sd_c_oe
      && !sbhe_n_c_oe && sa_c_oe == 2'h0 && cmd_n_c_oe == 4'h0)
      else $error("controller drives a line during a master phase");
   grant_first_a: assert property ($rose(mst_drv) |-> cpu_bus_grant && hold)
      else $error("master phase began without grant");
   hold_grant_a: assert property ($rose(hold) |-> ##[1:2] cpu_bus_grant)
      else $error("hold request not granted");
   low_meg_a: assert property (!low_meg_select_n |-> (la & `ISAB_LOW_MEG_MASK) == 24'h0)
      else $error("low megabyte indicator above one megabyte");
   sel_late_a: assert property ($fell(bios_rom_or_kbc_select_n) |-> $past(cmd_n) != 4'hf)
      else $error("select asserted before the command");
   // Chip select stays low three cycles on an unstretched ROM read
   rom_wait_a: assert property ($fell(bios_rom_or_kbc_select_n) && chrdy
      && (la & `ISAB_ROM_MASK) == `ISAB_ROM_BASE ##1 chrdy |-> ##1 bios_rom_or_kbc_select_n == 1'b0
      ##1 bios_rom_or_kbc_select_n)
      else $error("ROM cycle not one wait state");
endmodule : isab_asserts

/* File: bench/testbench.sv */
// Self-checking bench joining controller and card ends
`timescale 1ns/100ps
`include "isab_defs.svh"
module testbench;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic strap = 1'b1;
   logic [7:0] cfg = 8'h00;
   logic req_valid = 1'b0;
   isab_pkg::isab_owner_t owner = isab_pkg::ISAB_OWN_CPU;
   logic io = 1'b0;
   logic wr = 1'b0;
   logic [23:0] addr = 24'h0;
   logic [15:0] wdata = 16'h1234;
   logic wmem = 1'b0, wio = 1'b0, nrdy = 1'b0, zws_n = 1'b1, mreq = 1'b0;
   logic [3:0] mcmd = 4'hf;
   logic req_ready, done, wide, master_active, local_ready_in_n, mgrant, wstrobe;
   logic [15:0] rdata, slave_wdata;
   int fail_count = 0, compares = 0, cyc, sel_cnt, rf_cnt, lm_cnt;
   always #10 mclk = ~mclk;
   isab_if bus_if ();
   isab_ctrl isab_ctrl_inst (.mclk(mclk), .reset(reset), .bus(bus_if.ctrl),
      .ready_function_strap(strap), .cfg_3a(cfg), .req_valid(req_valid), .req_owner(owner),
      .req_io(io), .req_write(wr), .req_addr(addr), .req_bhe_n(1'b0), .req_wdata(wdata),
      .req_ready(req_ready), .done(done), .rdata(rdata), .wide(wide),
      .master_active(master_active), .local_ready_in_n(local_ready_in_n));
   // Card answers with the inverse of the write pattern so reads are told apart
   isab_peer isab_peer_inst (.mclk(mclk), .reset(reset), .bus(bus_if.peer),
      .slave_wide_mem(wmem), .slave_wide_io(wio), .slave_not_ready(nrdy),
      .slave_zero_wait_n(zws_n), .slave_rdata(~wdata), .mst_req(mreq), .mst_sa(2'h2),
      .mst_bhe_n(1'b0), .mst_cmd_n(mcmd), .mst_wdata(16'h5aa5), .mst_write(1'b1),
      .mst_granted(mgrant), .slave_wdata(slave_wdata), .slave_wstrobe(wstrobe));
   isab_asserts isab_asserts_inst (.mclk(mclk), .reset(reset), .ale(bus_if.ale),
      .hold(bus_if.hold), .cpu_bus_grant(bus_if.cpu_bus_grant), .chrdy(bus_if.chrdy),
      .low_meg_select_n(bus_if.low_meg_select_n), .la(bus_if.la), .cmd_n(bus_if.cmd_n),
      .bios_rom_or_kbc_select_n(bus_if.bios_rom_or_kbc_select_n), .sa_c_oe(bus_if.sa_c_oe),
      .cmd_n_c_oe(bus_if.cmd_n_c_oe), .sd_c_oe(bus_if.sd_c_oe), .sbhe_n_c_oe(bus_if.sbhe_n_c_oe),
      .refresh_active_n_n_c_oe(bus_if.refresh_active_n_n_c_oe), .mem_sixteen_bit_select_n_n_c_o(bus_if.mem_sixteen_bit_select_n_n_c_o),
      .mem_sixteen_bit_select_n_n_c_oe(bus_if.mem_sixteen_bit_select_n_n_c_oe));
   // Inputs move 1 ns after the edge so no race with the design's sampling
   task automatic step;
      @(posedge mclk);
      #1;
   endtask : step
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic do_reset(input logic s);
      reset = 1'b1;
      strap = s;
      repeat (6) step();
      reset = 1'b0;
   endtask : do_reset
   // One request; counts cycles to done and low cycles of select and refresh
   task automatic xfer(input isab_pkg::isab_owner_t o, input logic i, input logic w,
         input logic [23:0] a);
      owner = o;
      io = i;
      wr = w;
      addr = a;
      req_valid = 1'b1;
      cyc = 0;
      while (req_ready !== 1'b1 && cyc < 50) begin
         step();
         cyc++;
      end
      step();
      req_valid = 1'b0;
      cyc = 1;
      sel_cnt = 0;
      rf_cnt = 0;
      lm_cnt = 0;
      while (done !== 1'b1 && cyc < 300) begin
         if (bus_if.bios_rom_or_kbc_select_n === 1'b0) sel_cnt++;
         if (bus_if.low_meg_select_n === 1'b0) lm_cnt++;
         if (bus_if.refresh_active_n_n === 1'b0) rf_cnt++;
         step();
         cyc++;
      end
   endtask : xfer
   task automatic t_cpu;
      wmem = 1'b1;
      xfer(isab_pkg::ISAB_OWN_CPU, 1'b0, 1'b0, 24'h0a0000);
      check(rdata, 16'hedcb);
      check(wide, 1'b1);
      check(cyc, `ISAB_STD_WAITS + 5);
      check(lm_cnt, `ISAB_STD_WAITS + 4);
      xfer(isab_pkg::ISAB_OWN_CPU, 1'b0, 1'b0, 24'h100000);
      check(lm_cnt, 0);
      wdata = 16'ha55a;
      xfer(isab_pkg::ISAB_OWN_CPU, 1'b1, 1'b1, 24'h000300);
      check(slave_wdata, 16'ha55a);
      check(wstrobe, 1'b1);
      check(wide, 1'b0);
      wio = 1'b1;
      xfer(isab_pkg::ISAB_OWN_CPU, 1'b1, 1'b0, 24'h000300);
      check(wide, 1'b1);
      wio = 1'b0;
      $display("cpu test done");
   endtask : t_cpu
   task automatic t_rom_kbd;
      xfer(isab_pkg::ISAB_OWN_CPU, 1'b0, 1'b0, 24'h0f1234);
      check(cyc, `ISAB_ROM_WAITS + 5);
      check(sel_cnt, `ISAB_ROM_WAITS + 2);
      for (int k = 0; k < 6; k++) begin
         cfg = (k > 2) ? 8'h80 : 8'h00;
         addr = (k % 3 == 0) ? 24'h60 : ((k % 3 == 1) ? 24'h64 : 24'h61);
         xfer(isab_pkg::ISAB_OWN_CPU, 1'b1, 1'b0, addr);
         check(sel_cnt, (k < 2) ? `ISAB_STD_WAITS + 2 : 0);
      end
      $display("rom and keyboard test done");
   endtask : t_rom_kbd
   // Card holds channel ready low for 30 cycles, the cycle must stretch past that
   task automatic t_ready;
      nrdy = 1'b1;
      fork
         xfer(isab_pkg::ISAB_OWN_CPU, 1'b0, 1'b0, 24'h0a0000);
         begin
            repeat (30) step();
            nrdy = 1'b0;
         end
      join
      check(cyc > 30, 1'b1);
      $display("ready test done");
   endtask : t_ready
   task automatic t_master;
      mreq = 1'b1;
      mcmd = 4'he;
      fork
         xfer(isab_pkg::ISAB_OWN_MST, 1'b0, 1'b0, 24'h0);
         begin
            for (int n = 0; n < 50 && master_active !== 1'b1; n++) step();
            step();
            check(bus_if.sa, 2'h2);
            check(bus_if.cmd_n, 4'he);
            check(bus_if.sbhe_n, 1'b0);
            check(bus_if.mem_sixteen_bit_select_n_n, 1'b0);
            check(bus_if.sd, 16'h5aa5);
            check(bus_if.hold, 1'b1);
            check(mgrant, 1'b1);
            mreq = 1'b0;
            mcmd = 4'hf;
         end
      join
      $display("master test done");
   endtask : t_master
   task automatic t_ref_dma;
      xfer(isab_pkg::ISAB_OWN_REF, 1'b0, 1'b0, 24'h0);
      check(rf_cnt > 0, 1'b1);
      xfer(isab_pkg::ISAB_OWN_DMA, 1'b0, 1'b0, 24'h0a0000);
      check(cyc < 300, 1'b1);
      check(rf_cnt, 0);
      $display("refresh and dma test done");
   endtask : t_ref_dma
   task automatic t_strap;
      zws_n = 1'b0;
      step();
      check(local_ready_in_n, 1'b1);
      xfer(isab_pkg::ISAB_OWN_CPU, 1'b0, 1'b0, 24'h0a0000);
      check(cyc < `ISAB_STD_WAITS + 5, 1'b1);
      xfer(isab_pkg::ISAB_OWN_CPU, 1'b0, 1'b0, 24'h0f0000);
      check(cyc, `ISAB_ROM_WAITS + 5);
      do_reset(1'b0);
      check(local_ready_in_n, 1'b0);
      zws_n = 1'b1;
      step();
      check(local_ready_in_n, 1'b1);
      $display("strap test done");
   endtask : t_strap
   task automatic end_sim;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   initial begin
      do_reset(1'b1);
      t_cpu();
      t_rom_kbd();
      t_ready();
      t_master();
      t_ref_dma();
      t_strap();
      end_sim();
   end
   // Whole run needs well under 1000 cycles; this cuts a hang short
   initial begin
      repeat (5000) @(posedge mclk);
      fail_count++;
      end_sim();
   end
endmodule : testbench
